// *** core/ldsr_params.svh ***
`ifndef LDSR_PARAMS_SVH
`define LDSR_PARAMS_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define LDSR_CH4_DUTY_LOW_A   8'h1D
`define LDSR_CH4_DUTY_HIGH_A  8'h1E
`define LDSR_CH4_DUTY_LOW_B   8'h20
`define LDSR_CH4_DUTY_HIGH_B  8'h21
`define LDSR_CH5_CURRENT_A    8'h22
`define LDSR_CH5_DUTY_LOW_A   8'h23
`define LDSR_CH5_DUTY_HIGH_A  8'h24
`define LDSR_CH5_CURRENT_B    8'h25
`define LDSR_CH5_DUTY_LOW_B   8'h26
`define LDSR_CH5_DUTY_HIGH_B  8'h27
`define LDSR_CH6_CURRENT_A    8'h28
`define LDSR_CH6_DUTY_LOW_A   8'h29
`define LDSR_CH6_DUTY_HIGH_A  8'h2A
`define LDSR_CH6_CURRENT_B    8'h2B
`define LDSR_CH6_DUTY_LOW_B   8'h2C
`define LDSR_CH6_DUTY_HIGH_B  8'h2D
`define LDSR_CH7_CURRENT_A    8'h2E
`define LDSR_CH7_CURRENT_B    8'h31

// ****************************************************************
// Field positions
// ****************************************************************
`define LDSR_LOW_NIB_MSB      3
`define LDSR_CODE_MSB         5

// ****************************************************************
// Reset values
// ****************************************************************
`define LDSR_LOW_NIB_RST      4'hF
`define LDSR_HIGH_BYTE_RST    8'hFF
`define LDSR_CODE_RST         6'h3F
`define LDSR_DUTY_RST         12'hFFF
`define LDSR_RDATA_RST        8'h00

`endif

// *** core/ldsr_pkg.sv ***
package ldsr_pkg;

    // ************************************************************
    // Types
    // ************************************************************
    typedef logic [7:0]  ldsr_byte_t;
    typedef logic [3:0]  ldsr_nib_t;
    typedef logic [5:0]  ldsr_code_t;
    typedef logic [11:0] ldsr_duty_t;

    // ************************************************************
    // Alias address match
    // ************************************************************
    function automatic logic ldsr_hit(input ldsr_byte_t addr,
                                      input ldsr_byte_t off_a,
                                      input ldsr_byte_t off_b);
        ldsr_hit = (addr == off_a) || (addr == off_b);
    endfunction

endpackage

// *** core/ldsr_wr_if.sv ***
`timescale 1ns/1ps
`default_nettype none

interface ldsr_wr_if;
    logic              wr_en;
    ldsr_pkg::ldsr_byte_t addr;
    ldsr_pkg::ldsr_byte_t wdata;

    modport src (output wr_en, output addr, output wdata);
    modport dst (input wr_en, input addr, input wdata);
endinterface

`default_nettype wire

// *** core/ldsr_duty_chan.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "ldsr_params.svh"

module ldsr_duty_chan #(
    parameter logic [7:0] LOW_A  = 8'h00,
    parameter logic [7:0] LOW_B  = 8'h00,
    parameter logic [7:0] HIGH_A = 8'h00,
    parameter logic [7:0] HIGH_B = 8'h00
) (
    input  wire logic            clk,
    input  wire logic            nrst,
    ldsr_wr_if.dst               bus,
    output var  ldsr_pkg::ldsr_nib_t  low_nibble,
    output var  ldsr_pkg::ldsr_byte_t high_byte,
    output var  ldsr_pkg::ldsr_duty_t duty
);

    // ************************************************************
    // Duty storage
    // ************************************************************
    ldsr_pkg::ldsr_nib_t  low_q,  low_d;
    ldsr_pkg::ldsr_byte_t high_q, high_d;
    ldsr_pkg::ldsr_duty_t duty_q, duty_d;
    logic                 low_wr;
    logic                 high_wr;

    assign low_wr  = bus.wr_en && ldsr_pkg::ldsr_hit(bus.addr, LOW_A, LOW_B);
    assign high_wr = bus.wr_en && ldsr_pkg::ldsr_hit(bus.addr, HIGH_A, HIGH_B);

    always_comb begin
        low_d  = low_q;
        high_d = high_q;
        duty_d = duty_q;
        if (low_wr) begin
            low_d = bus.wdata[`LDSR_LOW_NIB_MSB:0];
        end
        if (high_wr) begin
            high_d = bus.wdata;
            duty_d = {bus.wdata, low_q};
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            low_q  <= `LDSR_LOW_NIB_RST;
            high_q <= `LDSR_HIGH_BYTE_RST;
            duty_q <= `LDSR_DUTY_RST;
        end else begin
            low_q  <= low_d;
            high_q <= high_d;
            duty_q <= duty_d;
        end
    end

    assign low_nibble = low_q;
    assign high_byte  = high_q;
    assign duty       = duty_q;

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    property p_low_pending;
        low_wr |=> (duty_q == $past(duty_q)) && (low_q == $past(bus.wdata[3:0]));
    endproperty
    a_low_pending: assert property (p_low_pending)
        else $error("duty moved on low write");

    property p_high_commit;
        high_wr |=> duty_q == {$past(bus.wdata), $past(low_q)};
    endproperty
    a_high_commit: assert property (p_high_commit)
        else $error("duty not committed on high write");

    property p_duty_needs_high;
        !high_wr |=> $stable(duty_q);
    endproperty
    a_duty_needs_high: assert property (p_duty_needs_high)
        else $error("duty changed without high write");

    property p_high_store;
        high_wr |=> high_q == $past(bus.wdata);
    endproperty
    a_high_store: assert property (p_high_store)
        else $error("high byte not stored");

    property p_duty_tracks_high;
        duty_q[11:4] == high_q;
    endproperty
    a_duty_tracks_high: assert property (p_duty_tracks_high)
        else $error("duty high part differs from high byte");

    property p_low_hold;
        !low_wr |=> $stable(low_q);
    endproperty
    a_low_hold: assert property (p_low_hold)
        else $error("low nibble changed without write");

    c_low_then_high: cover property (low_wr ##[1:8] high_wr);
    c_high_only: cover property (high_wr && !$past(low_wr));

endmodule

`default_nettype wire

// *** core/ldsr_cur_chan.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "ldsr_params.svh"

module ldsr_cur_chan #(
    parameter logic [7:0] CUR_A = 8'h00,
    parameter logic [7:0] CUR_B = 8'h00
) (
    input  wire logic            clk,
    input  wire logic            nrst,
    ldsr_wr_if.dst               bus,
    output var  ldsr_pkg::ldsr_code_t code
);

    // ************************************************************
    // Analog code storage
    // ************************************************************
    ldsr_pkg::ldsr_code_t code_q, code_d;
    logic                 cur_wr;

    assign cur_wr = bus.wr_en && ldsr_pkg::ldsr_hit(bus.addr, CUR_A, CUR_B);

    always_comb begin
        code_d = code_q;
        if (cur_wr) begin
            code_d = bus.wdata[`LDSR_CODE_MSB:0];
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            code_q <= `LDSR_CODE_RST;
        end else begin
            code_q <= code_d;
        end
    end

    assign code = code_q;

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    property p_code_store;
        cur_wr |=> code_q == $past(bus.wdata[5:0]);
    endproperty
    a_code_store: assert property (p_code_store)
        else $error("analog code not stored");

    property p_code_hold;
        !cur_wr |=> $stable(code_q);
    endproperty
    a_code_hold: assert property (p_code_hold)
        else $error("analog code changed without write");

    c_code_write: cover property (cur_wr);

endmodule

`default_nettype wire

// *** core/ldsr_top.sv ***
//Summary of operation
// - Low register holds duty bits 3:0, reset ones
// - High register holds duty bits 11:4, reset ones
// - Low write pends; high write updates duty
// - Analog code bits 5:0, reset ones
// - Low register bits 7:4 read zero
// - Current register bits 7:6 read zero
// - Channel 4 duty at 1D/20 and 1E/21
// - Channel 5 at 22/25, 23/26, 24/27
// - Channel 6 at 28/2B, 29/2C, 2A/2D
// - Channel 7 current at 2E and 31
// - Channel 7 code bits 5:0, reset ones
`timescale 1ns/1ps
`default_nettype none
`include "ldsr_params.svh"

module ldsr_top (
    input  wire logic        CLK_IN,
    input  wire logic        NRST_IN,
    input  wire logic        WR_EN_IN,
    input  wire logic        RD_EN_IN,
    input  wire logic [7:0]  ADDR_IN,
    input  wire logic [7:0]  WDATA_IN,
    output logic      [7:0]  RDATA_OUT,
    output logic             RVALID_OUT,
    output logic      [11:0] CH4_DUTY_OUT,
    output logic      [11:0] CH5_DUTY_OUT,
    output logic      [11:0] CH6_DUTY_OUT,
    output logic      [5:0]  CH5_CODE_OUT,
    output logic      [5:0]  CH6_CODE_OUT,
    output logic      [5:0]  CH7_CODE_OUT
);

    // ************************************************************
    // Write carrier
    // ************************************************************
    ldsr_wr_if wr_bus ();

    assign wr_bus.wr_en = WR_EN_IN;
    assign wr_bus.addr  = ADDR_IN;
    assign wr_bus.wdata = WDATA_IN;

    // ************************************************************
    // Channel storage
    // ************************************************************
    ldsr_pkg::ldsr_nib_t  ch4_duty_low_nibble;
    ldsr_pkg::ldsr_nib_t  ch5_duty_low_nibble;
    ldsr_pkg::ldsr_nib_t  ch6_duty_low_nibble;
    ldsr_pkg::ldsr_byte_t ch4_duty_high_byte;
    ldsr_pkg::ldsr_byte_t ch5_duty_high_byte;
    ldsr_pkg::ldsr_byte_t ch6_duty_high_byte;
    ldsr_pkg::ldsr_duty_t ch4_duty;
    ldsr_pkg::ldsr_duty_t ch5_duty;
    ldsr_pkg::ldsr_duty_t ch6_duty;
    ldsr_pkg::ldsr_code_t ch5_analog_code;
    ldsr_pkg::ldsr_code_t ch6_analog_code;
    ldsr_pkg::ldsr_code_t ch7_analog_code;

    ldsr_duty_chan #(
        .LOW_A  (`LDSR_CH4_DUTY_LOW_A),
        .LOW_B  (`LDSR_CH4_DUTY_LOW_B),
        .HIGH_A (`LDSR_CH4_DUTY_HIGH_A),
        .HIGH_B (`LDSR_CH4_DUTY_HIGH_B)
    ) u_ch4_duty (
        .clk        (CLK_IN),
        .nrst       (NRST_IN),
        .bus        (wr_bus),
        .low_nibble (ch4_duty_low_nibble),
        .high_byte  (ch4_duty_high_byte),
        .duty       (ch4_duty)
    );

    ldsr_duty_chan #(
        .LOW_A  (`LDSR_CH5_DUTY_LOW_A),
        .LOW_B  (`LDSR_CH5_DUTY_LOW_B),
        .HIGH_A (`LDSR_CH5_DUTY_HIGH_A),
        .HIGH_B (`LDSR_CH5_DUTY_HIGH_B)
    ) u_ch5_duty (
        .clk        (CLK_IN),
        .nrst       (NRST_IN),
        .bus        (wr_bus),
        .low_nibble (ch5_duty_low_nibble),
        .high_byte  (ch5_duty_high_byte),
        .duty       (ch5_duty)
    );

    ldsr_duty_chan #(
        .LOW_A  (`LDSR_CH6_DUTY_LOW_A),
        .LOW_B  (`LDSR_CH6_DUTY_LOW_B),
        .HIGH_A (`LDSR_CH6_DUTY_HIGH_A),
        .HIGH_B (`LDSR_CH6_DUTY_HIGH_B)
    ) u_ch6_duty (
        .clk        (CLK_IN),
        .nrst       (NRST_IN),
        .bus        (wr_bus),
        .low_nibble (ch6_duty_low_nibble),
        .high_byte  (ch6_duty_high_byte),
        .duty       (ch6_duty)
    );

    ldsr_cur_chan #(
        .CUR_A (`LDSR_CH5_CURRENT_A),
        .CUR_B (`LDSR_CH5_CURRENT_B)
    ) u_ch5_cur (
        .clk  (CLK_IN),
        .nrst (NRST_IN),
        .bus  (wr_bus),
        .code (ch5_analog_code)
    );

    ldsr_cur_chan #(
        .CUR_A (`LDSR_CH6_CURRENT_A),
        .CUR_B (`LDSR_CH6_CURRENT_B)
    ) u_ch6_cur (
        .clk  (CLK_IN),
        .nrst (NRST_IN),
        .bus  (wr_bus),
        .code (ch6_analog_code)
    );

    ldsr_cur_chan #(
        .CUR_A (`LDSR_CH7_CURRENT_A),
        .CUR_B (`LDSR_CH7_CURRENT_B)
    ) u_ch7_cur (
        .clk  (CLK_IN),
        .nrst (NRST_IN),
        .bus  (wr_bus),
        .code (ch7_analog_code)
    );

    assign CH4_DUTY_OUT = ch4_duty;
    assign CH5_DUTY_OUT = ch5_duty;
    assign CH6_DUTY_OUT = ch6_duty;
    assign CH5_CODE_OUT = ch5_analog_code;
    assign CH6_CODE_OUT = ch6_analog_code;
    assign CH7_CODE_OUT = ch7_analog_code;

    // ************************************************************
    // Read decode
    // ************************************************************
    ldsr_pkg::ldsr_byte_t rd_sel;
    ldsr_pkg::ldsr_byte_t rdata_q, rdata_d;
    logic                 rvalid_q, rvalid_d;

    always_comb begin
        rd_sel = `LDSR_RDATA_RST;
        if (ldsr_pkg::ldsr_hit(ADDR_IN, `LDSR_CH4_DUTY_LOW_A,
                               `LDSR_CH4_DUTY_LOW_B)) begin
            rd_sel = {4'h0, ch4_duty_low_nibble};
        end else if (ldsr_pkg::ldsr_hit(ADDR_IN, `LDSR_CH4_DUTY_HIGH_A,
                                        `LDSR_CH4_DUTY_HIGH_B)) begin
            rd_sel = ch4_duty_high_byte;
        end else if (ldsr_pkg::ldsr_hit(ADDR_IN, `LDSR_CH5_CURRENT_A,
                                        `LDSR_CH5_CURRENT_B)) begin
            rd_sel = {2'h0, ch5_analog_code};
        end else if (ldsr_pkg::ldsr_hit(ADDR_IN, `LDSR_CH5_DUTY_LOW_A,
                                        `LDSR_CH5_DUTY_LOW_B)) begin
            rd_sel = {4'h0, ch5_duty_low_nibble};
        end else if (ldsr_pkg::ldsr_hit(ADDR_IN, `LDSR_CH5_DUTY_HIGH_A,
                                        `LDSR_CH5_DUTY_HIGH_B)) begin
            rd_sel = ch5_duty_high_byte;
        end else if (ldsr_pkg::ldsr_hit(ADDR_IN, `LDSR_CH6_CURRENT_A,
                                        `LDSR_CH6_CURRENT_B)) begin
            rd_sel = {2'h0, ch6_analog_code};
        end else if (ldsr_pkg::ldsr_hit(ADDR_IN, `LDSR_CH6_DUTY_LOW_A,
                                        `LDSR_CH6_DUTY_LOW_B)) begin
            rd_sel = {4'h0, ch6_duty_low_nibble};
        end else if (ldsr_pkg::ldsr_hit(ADDR_IN, `LDSR_CH6_DUTY_HIGH_A,
                                        `LDSR_CH6_DUTY_HIGH_B)) begin
            rd_sel = ch6_duty_high_byte;
        end else if (ldsr_pkg::ldsr_hit(ADDR_IN, `LDSR_CH7_CURRENT_A,
                                        `LDSR_CH7_CURRENT_B)) begin
            rd_sel = {2'h0, ch7_analog_code};
        end
    end

    always_comb begin
        rvalid_d = RD_EN_IN;
        rdata_d  = rdata_q;
        if (RD_EN_IN) begin
            rdata_d = rd_sel;
        end
    end

    always_ff @(posedge CLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            rdata_q  <= `LDSR_RDATA_RST;
            rvalid_q <= 1'b0;
        end else begin
            rdata_q  <= rdata_d;
            rvalid_q <= rvalid_d;
        end
    end

    assign RDATA_OUT  = rdata_q;
    assign RVALID_OUT = rvalid_q;

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (!NRST_IN);

    property p_ch4_alias;
        WR_EN_IN && ADDR_IN == 8'h21 |=> ch4_duty[11:4] == $past(WDATA_IN);
    endproperty
    a_ch4_alias: assert property (p_ch4_alias)
        else $error("ch4 high alias write lost");

    property p_ch5_alias;
        WR_EN_IN && ADDR_IN == 8'h25 |=> ch5_analog_code == $past(WDATA_IN[5:0]);
    endproperty
    a_ch5_alias: assert property (p_ch5_alias)
        else $error("ch5 current alias write lost");

    property p_ch6_pair;
        WR_EN_IN && ADDR_IN == 8'h2C ##1 WR_EN_IN && ADDR_IN == 8'h2A
            |=> ch6_duty == {$past(WDATA_IN), $past(WDATA_IN[3:0], 2)};
    endproperty
    a_ch6_pair: assert property (p_ch6_pair)
        else $error("ch6 duty pair not formed");

    property p_ch7_alias;
        WR_EN_IN && ADDR_IN == 8'h31 |=> ch7_analog_code == $past(WDATA_IN[5:0]);
    endproperty
    a_ch7_alias: assert property (p_ch7_alias)
        else $error("ch7 current alias write lost");

    property p_rd_low_res;
        RD_EN_IN && ADDR_IN == 8'h1D |=> RVALID_OUT && RDATA_OUT[7:4] == 4'h0;
    endproperty
    a_rd_low_res: assert property (p_rd_low_res)
        else $error("low register reserved bits not zero");

    property p_rd_cur_res;
        RD_EN_IN && ADDR_IN == 8'h2E |=> RDATA_OUT == {2'h0, ch7_analog_code};
    endproperty
    a_rd_cur_res: assert property (p_rd_cur_res)
        else $error("current readback wrong");

    property p_rd_unmapped;
        RD_EN_IN && ADDR_IN == 8'h2F |=> RDATA_OUT == 8'h00;
    endproperty
    a_rd_unmapped: assert property (p_rd_unmapped)
        else $error("unmapped read not zero");

    c_rd_high: cover property (RD_EN_IN && ADDR_IN == 8'h24);
    c_wr_alias_b: cover property (WR_EN_IN && ADDR_IN == 8'h2D);

endmodule

`default_nettype wire

// *** tb/ldsr_host.sv ***
`timescale 1ns/1ps
`default_nettype none

module ldsr_host (
    input  wire logic       clk_in,
    input  wire logic [7:0] rdata_in,
    input  wire logic       rvalid_in,
    output var  logic       wr_en_out,
    output var  logic       rd_en_out,
    output var  logic [7:0] addr_out,
    output var  logic [7:0] wdata_out
);

    // ************************************************************
    // Idle bus at time zero
    // ************************************************************
    initial begin
        wr_en_out = 1'b0;
        rd_en_out = 1'b0;
        addr_out  = 8'h00;
        wdata_out = 8'h00;
    end

    // ************************************************************
    // Write, strobe kept up when hold is set
    // ************************************************************
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d,
                          input logic hold);
        @(posedge clk_in);
        wr_en_out <= 1'b1;
        addr_out  <= a;
        wdata_out <= d;
        if (!hold) begin
            @(posedge clk_in);
            wr_en_out <= 1'b0;
            addr_out  <= ~a;
            wdata_out <= ~d;
        end
    endtask

    // ************************************************************
    // Read, answer taken one cycle after the request
    // ************************************************************
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d,
                          output logic v);
        @(posedge clk_in);
        rd_en_out <= 1'b1;
        addr_out  <= a;
        @(posedge clk_in);
        rd_en_out <= 1'b0;
        addr_out  <= ~a;
        @(negedge clk_in);
        v = rvalid_in;
        d = rdata_in;
    endtask

endmodule

`default_nettype wire

// *** tb/ldsr_top_tb.sv ***
`timescale 1ns/1ps
`default_nettype none

module ldsr_top_tb;

    // ************************************************************
    // Signals
    // ************************************************************
    logic        clk;
    logic        rst_n;
    logic        wr_en;
    logic        rd_en;
    logic [7:0]  addr;
    logic [7:0]  wdata;
    logic [7:0]  rdata;
    logic        rvalid;
    logic [11:0] ch4_duty;
    logic [11:0] ch5_duty;
    logic [11:0] ch6_duty;
    logic [5:0]  ch5_code;
    logic [5:0]  ch6_code;
    logic [5:0]  ch7_code;
    logic [7:0]  rd;
    logic        vld;
    int          error_cnt;
    int          samples_checked;
    int          cyc;
    int          i;

    // ************************************************************
    // Tables: write addr, read addr, write data, expected read
    // ************************************************************
    logic [31:0] rows [0:12] = '{
        32'h1D20FF0F, 32'h2326A505, 32'h292C3C0C, 32'h1E211212,
        32'h24273434, 32'h2A2D5656, 32'h2225FF3F, 32'h282BC101,
        32'h2E317A3A, 32'h312E1515, 32'h1C1C5500, 32'h2F305500,
        32'h32335500};
    logic [15:0] rst_tab [0:17] = '{
        16'h1D0F, 16'h1EFF, 16'h200F, 16'h21FF, 16'h223F, 16'h230F,
        16'h24FF, 16'h253F, 16'h260F, 16'h27FF, 16'h283F, 16'h290F,
        16'h2AFF, 16'h2B3F, 16'h2C0F, 16'h2DFF, 16'h2E3F, 16'h313F};

    // ************************************************************
    // Clock, design and host
    // ************************************************************
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    ldsr_top u_dut (
        .CLK_IN       (clk),
        .NRST_IN      (rst_n),
        .WR_EN_IN     (wr_en),
        .RD_EN_IN     (rd_en),
        .ADDR_IN      (addr),
        .WDATA_IN     (wdata),
        .RDATA_OUT    (rdata),
        .RVALID_OUT   (rvalid),
        .CH4_DUTY_OUT (ch4_duty),
        .CH5_DUTY_OUT (ch5_duty),
        .CH6_DUTY_OUT (ch6_duty),
        .CH5_CODE_OUT (ch5_code),
        .CH6_CODE_OUT (ch6_code),
        .CH7_CODE_OUT (ch7_code)
    );

    ldsr_host u_host (
        .clk_in    (clk),
        .rdata_in  (rdata),
        .rvalid_in (rvalid),
        .wr_en_out (wr_en),
        .rd_en_out (rd_en),
        .addr_out  (addr),
        .wdata_out (wdata)
    );

    // ************************************************************
    // Tasks
    // ************************************************************
    task automatic check(input string name, input logic [11:0] seen,
                         input logic [11:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected %s: expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic complete_run;
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic reset_dut;
        rst_n <= 1'b0;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        @(negedge clk);
    endtask

    task automatic read_chk(input logic [7:0] a, input logic [7:0] exp);
        u_host.rd_reg(a, rd, vld);
        check("rvalid", {11'h000, vld}, 12'h001);
        check("rdata", {4'h0, rd}, {4'h0, exp});
    endtask

    // ************************************************************
    // Timeout
    // ************************************************************
    always @(posedge clk) begin
        cyc++;
        if (cyc == 2000) begin
            error_cnt++;
            complete_run();
        end
    end

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        rst_n = 1'b0;
        error_cnt = 0;
        samples_checked = 0;
        cyc = 0;
        reset_dut();
        check("ch4 duty", ch4_duty, 12'hFFF);
        check("ch5 duty", ch5_duty, 12'hFFF);
        check("ch6 duty", ch6_duty, 12'hFFF);
        check("ch5 code", {6'h00, ch5_code}, 12'h03F);
        check("ch6 code", {6'h00, ch6_code}, 12'h03F);
        check("ch7 code", {6'h00, ch7_code}, 12'h03F);
        for (i = 0; i < 18; i++) begin
            read_chk(rst_tab[i][15:8], rst_tab[i][7:0]);
        end
        $display("test reset values done");

        for (i = 0; i < 13; i++) begin
            u_host.wr_reg(rows[i][31:24], rows[i][15:8], 1'b0);
            read_chk(rows[i][23:16], rows[i][7:0]);
        end
        check("ch4 duty", ch4_duty, 12'h12F);
        check("ch5 duty", ch5_duty, 12'h345);
        check("ch6 duty", ch6_duty, 12'h56C);
        check("ch5 code", {6'h00, ch5_code}, 12'h03F);
        check("ch6 code", {6'h00, ch6_code}, 12'h001);
        check("ch7 code", {6'h00, ch7_code}, 12'h015);
        $display("test table done");

        u_host.wr_reg(8'h26, 8'h0A, 1'b0);
        @(negedge clk);
        check("ch5 duty pending", ch5_duty, 12'h345);
        read_chk(8'h23, 8'h0A);
        u_host.wr_reg(8'h23, 8'h01, 1'b1);
        u_host.wr_reg(8'h26, 8'h07, 1'b1);
        u_host.wr_reg(8'h24, 8'hAB, 1'b0);
        @(negedge clk);
        check("ch5 duty joined", ch5_duty, 12'hAB7);
        check("ch4 duty kept", ch4_duty, 12'h12F);
        u_host.wr_reg(8'h2C, 8'hF3, 1'b1);
        u_host.wr_reg(8'h2D, 8'h9E, 1'b0);
        @(negedge clk);
        check("ch6 duty joined", ch6_duty, 12'h9E3);
        $display("test pending low nibble done");

        reset_dut();
        check("ch5 duty", ch5_duty, 12'hFFF);
        check("ch7 code", {6'h00, ch7_code}, 12'h03F);
        read_chk(8'h24, 8'hFF);
        read_chk(8'h2C, 8'h0F);
        $display("test mid-run reset done");
        complete_run();
    end

endmodule

`default_nettype wire
